// *** cie_pkg.sv ***
// constants, layouts and types of the interrupt entry and exit block
package cie_pkg;

    // widths and counts
    localparam int PC_W = 15;
    localparam int NSYNC = 2;
    localparam int NASYNC = 1;
    localparam int NCORE = NSYNC + NASYNC;
    localparam int PERIPH_W = 8;
    localparam int NIRQ = 4;
    localparam int ADDR_W = 12;

    // fixed vector for interrupt entry
    localparam logic [PC_W-1:0] VECTOR_ADDR = 15'h0004;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_PFLAG1 = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_PFLAG2 = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_PEN1 = 12'h00c;
    localparam logic [ADDR_W-1:0] OFS_PEN2 = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_ISTAT = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_IEN = 12'h018;
    localparam logic [ADDR_W-1:0] OFS_ICLR = 12'h01c;
    localparam logic [ADDR_W-1:0] OFS_STATE = 12'h020;
    localparam logic [ADDR_W-1:0] OFS_SHADOW = 12'h024;

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [PERIPH_W-1:0] PFLAG_RST = 8'h00;
    localparam logic [PERIPH_W-1:0] PEN_RST = 8'h00;
    localparam logic [NIRQ-1:0] IEN_RST = 4'h0;

    // block status event positions
    localparam int EV_ENTRY = 0;
    localparam int EV_RETURN = 1;
    localparam int EV_OVF = 2;
    localparam int EV_UNF = 3;

    // core interrupt control word: bit 7 global, bit 6 group, 5:3 enables, 2:0 flags
    typedef struct packed {
        logic global_int_enable;
        logic peripheral_group_int_enable;
        logic [NCORE-1:0] en;
        logic [NCORE-1:0] flag;
    } cie_ctrl_t;

    // critical context copied to the shadow on entry
    typedef struct packed {
        logic [7:0] acc;
        logic [4:0] alu_flags;
        logic [4:0] bank_sel;
        logic [6:0] pc_high;
    } cie_ctx_t;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_FLUSH = 3'b010,
        ST_VECTOR = 3'b100
    } cie_state_t;

endpackage : cie_pkg

// *** cie_sync3.sv ***
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module cie_sync3 #(
    parameter int W = 1
) (
    // clock, reset and clock enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cen,
    // asynchronous input and filtered level
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] level
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] level_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else if (cen) begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // level follows only where the last two stages agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_q <= '0;
        end else if (cen) begin
            level_q <= (s2_q & s3_q) | (level_q & (s2_q | s3_q));
        end
    end

    assign level = level_q;

endmodule : cie_sync3

// *** cie_ctrl.sv ***
// interrupt entry and exit sequencer with apb register file
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module cie_ctrl import cie_pkg::*; #(
    parameter int STACK_DEPTH = 16
) (
    // clock, reset, clock enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cen,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // event sources
    input wire logic [NSYNC-1:0] core_evt,
    input wire logic [NASYNC-1:0] async_evt_pin,
    input wire logic [PERIPH_W-1:0] periph_evt_one,
    input wire logic [PERIPH_W-1:0] periph_evt_two,
    // processor core
    input wire logic [PC_W-1:0] cpu_pc,
    input wire cie_ctx_t cpu_ctx,
    input wire logic return_from_interrupt_instr,
    input wire logic cpu_two_cycle,
    output logic flush_prefetch,
    output logic pc_load,
    output logic [PC_W-1:0] pc_load_addr,
    output cie_ctx_t ctx_restore,
    output logic ctx_restore_valid,
    output logic global_int_enable,
    // block interrupt
    output logic irq
);

    localparam int SPW = $clog2(STACK_DEPTH);

    function automatic logic pend_fn(input logic [PERIPH_W-1:0] f, input logic [PERIPH_W-1:0] e);
        pend_fn = |(f & e);
    endfunction : pend_fn

    cie_ctrl_t ctrl_q;
    logic [PERIPH_W-1:0] pflag1_q;
    logic [PERIPH_W-1:0] pflag2_q;
    logic [PERIPH_W-1:0] pen1_q;
    logic [PERIPH_W-1:0] pen2_q;
    logic [NIRQ-1:0] istat_q;
    logic [NIRQ-1:0] istat_d;
    logic [NIRQ-1:0] ien_q;
    logic irq_q;
    cie_state_t state_q;
    cie_ctx_t shadow_q;
    cie_ctx_t ctx_restore_q;
    logic ctx_restore_valid_q;
    logic flush_q;
    logic pc_load_q;
    logic [PC_W-1:0] pc_load_addr_q;
    logic [PC_W-1:0] stack_mem [STACK_DEPTH];
    logic [SPW-1:0] sp_q;
    logic [SPW:0] depth_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] rd_d;
    logic err_d;
    logic [NASYNC-1:0] async_lvl;
    logic [NASYNC-1:0] async_prev_q;
    logic [NCORE-1:0] core_set_w;
    logic access_w;
    logic wr_w;
    logic pend_w;
    logic take_w;
    logic ret_w;
    logic [SPW-1:0] sp_dec_w;

    cie_sync3 #(.W(NASYNC)) u_async_sync (
        .pclk(pclk),
        .presetn(presetn),
        .cen(cen),
        .async_in(async_evt_pin),
        .level(async_lvl)
    );

    // apb handshake: one wait state, answer on the second access cycle
    assign access_w = psel && penable && !pready_q;
    assign wr_w = cen && psel && penable && pready_q && pwrite;

    // captured asynchronous rising edges join the synchronous core events
    assign core_set_w = {async_lvl & ~async_prev_q, core_evt};

    assign pend_w = global_int_enable && (pend_fn(PERIPH_W'(ctrl_q.flag), PERIPH_W'(ctrl_q.en))
        || (ctrl_q.peripheral_group_int_enable && (pend_fn(pflag1_q, pen1_q)
        || pend_fn(pflag2_q, pen2_q))));

    // entry waits for the second cycle of a two-cycle instruction
    assign take_w = cen && state_q == ST_RUN && pend_w && !cpu_two_cycle && !ret_w;
    assign ret_w = cen && state_q == ST_RUN && return_from_interrupt_instr;
    assign sp_dec_w = (sp_q == '0) ? SPW'(STACK_DEPTH - 1) : sp_q - 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            async_prev_q <= '0;
        end else if (cen) begin
            async_prev_q <= async_lvl;
        end
    end

    // core control word: global enable, group enable, core enables and flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
        end else if (cen) begin
            if (wr_w && paddr == OFS_CTRL) begin
                ctrl_q <= cie_ctrl_t'(pwdata[7:0]);
            end
            ctrl_q.flag <= ((wr_w && paddr == OFS_CTRL) ? pwdata[NCORE-1:0] : ctrl_q.flag)
                | core_set_w;
            if (take_w) begin
                ctrl_q.global_int_enable <= 1'b0;
            end else if (ret_w) begin
                ctrl_q.global_int_enable <= 1'b1;
            end else if (wr_w && paddr == OFS_CTRL) begin
                ctrl_q.global_int_enable <= pwdata[7];
            end
        end
    end

    // peripheral flags: event set wins over a software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pflag1_q <= PFLAG_RST;
            pflag2_q <= PFLAG_RST;
        end else if (cen) begin
            pflag1_q <= ((wr_w && paddr == OFS_PFLAG1) ? pwdata[PERIPH_W-1:0] : pflag1_q)
                | periph_evt_one;
            pflag2_q <= ((wr_w && paddr == OFS_PFLAG2) ? pwdata[PERIPH_W-1:0] : pflag2_q)
                | periph_evt_two;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pen1_q <= PEN_RST;
            pen2_q <= PEN_RST;
        end else if (wr_w) begin
            if (paddr == OFS_PEN1) begin
                pen1_q <= pwdata[PERIPH_W-1:0];
            end else if (paddr == OFS_PEN2) begin
                pen2_q <= pwdata[PERIPH_W-1:0];
            end
        end
    end

    // sequencer: run, flush with push, vector load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_RUN;
        end else if (cen) begin
            case (state_q)
                ST_RUN: begin
                    if (take_w) begin
                        state_q <= ST_FLUSH;
                    end
                end
                ST_FLUSH: begin
                    state_q <= ST_VECTOR;
                end
                ST_VECTOR: begin
                    state_q <= ST_RUN;
                end
                default: begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end

    // core-facing strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flush_q <= 1'b0;
            pc_load_q <= 1'b0;
            pc_load_addr_q <= '0;
            ctx_restore_valid_q <= 1'b0;
        end else if (cen) begin
            flush_q <= take_w;
            pc_load_q <= (state_q == ST_FLUSH) || ret_w;
            ctx_restore_valid_q <= ret_w;
            if (state_q == ST_FLUSH) begin
                pc_load_addr_q <= VECTOR_ADDR;
            end else if (ret_w) begin
                pc_load_addr_q <= stack_mem[sp_dec_w];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shadow_q <= '0;
            ctx_restore_q <= '0;
        end else if (cen) begin
            if (take_w) begin
                shadow_q <= cpu_ctx;
            end
            if (ret_w) begin
                ctx_restore_q <= shadow_q;
            end
        end
    end

    // hardware return stack
    always_ff @(posedge pclk) begin
        if (take_w) begin
            stack_mem[sp_q] <= cpu_pc;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_q <= '0;
            depth_q <= '0;
        end else if (take_w) begin
            sp_q <= (sp_q == SPW'(STACK_DEPTH - 1)) ? '0 : sp_q + 1'b1;
            if (depth_q != (SPW + 1)'(STACK_DEPTH)) begin
                depth_q <= depth_q + 1'b1;
            end
        end else if (ret_w) begin
            sp_q <= sp_dec_w;
            if (depth_q != '0) begin
                depth_q <= depth_q - 1'b1;
            end
        end
    end

    // block status: set wins over write-one-to-clear
    always_comb begin
        istat_d = istat_q;
        if (wr_w && paddr == OFS_ICLR) begin
            istat_d = istat_d & ~pwdata[NIRQ-1:0];
        end
        istat_d[EV_ENTRY] = istat_d[EV_ENTRY] | take_w;
        istat_d[EV_RETURN] = istat_d[EV_RETURN] | ret_w;
        istat_d[EV_OVF] = istat_d[EV_OVF]
            | (take_w && depth_q == (SPW + 1)'(STACK_DEPTH));
        istat_d[EV_UNF] = istat_d[EV_UNF] | (ret_w && depth_q == '0);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_q <= '0;
            ien_q <= IEN_RST;
            irq_q <= 1'b0;
        end else if (cen) begin
            istat_q <= istat_d;
            if (wr_w && paddr == OFS_IEN) begin
                ien_q <= pwdata[NIRQ-1:0];
            end
            irq_q <= |(istat_d & ((wr_w && paddr == OFS_IEN) ? pwdata[NIRQ-1:0] : ien_q));
        end
    end

    // read decode
    always_comb begin
        rd_d = '0;
        err_d = 1'b0;
        if (paddr == OFS_CTRL) begin
            rd_d = 32'(ctrl_q);
        end else if (paddr == OFS_PFLAG1) begin
            rd_d = 32'(pflag1_q);
        end else if (paddr == OFS_PFLAG2) begin
            rd_d = 32'(pflag2_q);
        end else if (paddr == OFS_PEN1) begin
            rd_d = 32'(pen1_q);
        end else if (paddr == OFS_PEN2) begin
            rd_d = 32'(pen2_q);
        end else if (paddr == OFS_ISTAT) begin
            rd_d = 32'(istat_q);
        end else if (paddr == OFS_IEN) begin
            rd_d = 32'(ien_q);
        end else if (paddr == OFS_ICLR) begin
            rd_d = '0;
        end else if (paddr == OFS_STATE) begin
            rd_d = 32'({depth_q, sp_q, state_q});
        end else if (paddr == OFS_SHADOW) begin
            rd_d = 32'(shadow_q);
        end else begin
            err_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (cen) begin
            pready_q <= access_w;
            pslverr_q <= access_w && err_d;
            if (access_w && !pwrite) begin
                prdata_q <= rd_d;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign flush_prefetch = flush_q;
    assign pc_load = pc_load_q;
    assign pc_load_addr = pc_load_addr_q;
    assign ctx_restore = ctx_restore_q;
    assign ctx_restore_valid = ctx_restore_valid_q;
    assign global_int_enable = ctrl_q.global_int_enable;
    assign irq = irq_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_reset_disabled: assert property ($rose(presetn) |-> !global_int_enable && !flush_q)
        else $error("global enable set after reset");
    a_entry_enables: assert property ($rose(flush_q) |-> $past(global_int_enable)
        && ($past(|(ctrl_q.flag & ctrl_q.en)) || ($past(ctrl_q.peripheral_group_int_enable)
        && $past(|(pflag1_q & pen1_q) || |(pflag2_q & pen2_q)))))
        else $error("entry without enabled request");
    a_flag_sets: assert property (cen && core_evt[0] |=> ctrl_q.flag[0])
        else $error("core flag not set by event");
    a_entry_actions: assert property (take_w |=> flush_q && !global_int_enable
        && stack_mem[$past(sp_q)] == $past(cpu_pc))
        else $error("entry did not flush, clear or push");
    a_shadow_save: assert property (take_w |=> shadow_q == $past(cpu_ctx))
        else $error("context not saved on entry");
    a_vector_load: assert property (flush_q && cen |=> pc_load_q
        && pc_load_addr_q == VECTOR_ADDR)
        else $error("vector not loaded after flush");
    a_disabled_quiet: assert property (cen && !global_int_enable && !ret_w |=> !flush_q)
        else $error("redirect while global enable clear");
    a_return_actions: assert property (ret_w |=> global_int_enable && pc_load_q
        && ctx_restore_valid_q && ctx_restore_q == $past(shadow_q))
        else $error("return did not restore");
    a_sync_latency: assert property ((cen && core_evt[0] && ctrl_q.en[0] && global_int_enable
        && state_q == ST_RUN && !ret_w && !take_w) ##1 (cen && !ret_w)[*3]
        |-> ##[0:1] (pc_load_q && pc_load_addr_q == VECTOR_ADDR))
        else $error("synchronous latency exceeded");
    a_async_capture: assert property (cen && async_lvl[0] && !async_prev_q[0]
        |=> ctrl_q.flag[NSYNC])
        else $error("async event not captured");
    c_entry: cover property (take_w ##1 flush_q ##1 pc_load_q);
    c_return: cover property (ret_w ##1 ctx_restore_valid_q);
    c_reentry: cover property (ret_w ##[1:3] take_w);
    c_two_cycle: cover property (pend_w && cpu_two_cycle ##1 take_w);

endmodule : cie_ctrl

// *** cie_core_model.sv ***
// processor core model: running pc, moving context, return and two-cycle instruction commands
`timescale 1ns/100ps
module cie_core_model import cie_pkg::*; (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // commands from the bench
    input wire logic ret_cmd,
    input wire logic two_cmd,
    // redirect and restore from the block
    input wire logic pc_load,
    input wire logic [PC_W-1:0] pc_load_addr,
    input wire logic ctx_restore_valid,
    input wire cie_ctx_t ctx_restore,
    // core state seen by the block
    output logic [PC_W-1:0] cpu_pc,
    output cie_ctx_t cpu_ctx,
    output logic return_from_interrupt_instr,
    output logic cpu_two_cycle
);
    assign return_from_interrupt_instr = ret_cmd;
    assign cpu_two_cycle = two_cmd;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_pc <= 15'h0100;
        end else if (pc_load) begin
            cpu_pc <= pc_load_addr;
        end else begin
            cpu_pc <= cpu_pc + 15'h0001;
        end
    end

    // context moves every cycle so a stale shadow shows
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_ctx <= cie_ctx_t'(25'h012_3457);
        end else if (ctx_restore_valid) begin
            cpu_ctx <= ctx_restore;
        end else begin
            cpu_ctx <= cie_ctx_t'(cpu_ctx + 25'h000_3a5b);
        end
    end
endmodule : cie_core_model

// *** cie_ctrl_tb_top.sv ***
// self-checking bench for the interrupt entry and exit block
`timescale 1ns/100ps
module cie_ctrl_tb_top import cie_pkg::*; ;
    typedef struct {
        logic w;
        logic [ADDR_W-1:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic er;
    } cie_row_t;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic cen, ret_cmd, two_cmd, async_pin, ret_instr, cpu_two_cycle;
    logic flush_prefetch, pc_load, ctx_restore_valid, global_int_enable, irq;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [NSYNC-1:0] core_evt;
    logic [PERIPH_W-1:0] pev1, pev2;
    logic [PC_W-1:0] cpu_pc, pc_load_addr, prev_pc, exp_pc;
    cie_ctx_t cpu_ctx, ctx_restore, prev_ctx, exp_ctx;
    int failures, num_checks, fl_cnt, lat;
    cie_row_t rows[16];

    cie_ctrl cie_ctrl_i (.pclk(pclk), .presetn(presetn), .cen(cen), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_evt(core_evt),
        .async_evt_pin(async_pin), .periph_evt_one(pev1), .periph_evt_two(pev2),
        .cpu_pc(cpu_pc), .cpu_ctx(cpu_ctx), .return_from_interrupt_instr(ret_instr),
        .cpu_two_cycle(cpu_two_cycle), .flush_prefetch(flush_prefetch),
        .pc_load(pc_load), .pc_load_addr(pc_load_addr), .ctx_restore(ctx_restore),
        .ctx_restore_valid(ctx_restore_valid), .global_int_enable(global_int_enable),
        .irq(irq));

    cie_core_model cie_core_model_i (.pclk(pclk), .presetn(presetn), .ret_cmd(ret_cmd),
        .two_cmd(two_cmd), .pc_load(pc_load), .pc_load_addr(pc_load_addr),
        .ctx_restore_valid(ctx_restore_valid), .ctx_restore(ctx_restore),
        .cpu_pc(cpu_pc), .cpu_ctx(cpu_ctx), .return_from_interrupt_instr(ret_instr),
        .cpu_two_cycle(cpu_two_cycle));

    always #12.5 pclk = ~pclk;

    // pc and context of the take cycle, kept for the return
    always @(posedge pclk) begin
        prev_pc <= cpu_pc;
        prev_ctx <= cpu_ctx;
        if (flush_prefetch === 1'b1) begin
            exp_pc <= prev_pc;
            exp_ctx <= prev_ctx;
            fl_cnt <= fl_cnt + 1;
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            chk("apb ready", 32'h0, 32'h0000_0001);
            end_of_test();
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // waits for entry; lat ends as cycles from the event to the vector load
    task automatic ent(input int n0);
        lat = n0;
        repeat (40) begin
            @(posedge pclk);
            if (flush_prefetch === 1'b1) break;
            lat++;
        end
        if (flush_prefetch !== 1'b1) begin
            chk("entry wait", 32'h0, 32'h0000_0001);
            end_of_test();
        end
        chk("gie at entry", 32'(global_int_enable), 32'h0);
        @(posedge pclk);
        lat++;
        chk("entry load", 32'(pc_load), 32'h0000_0001);
        chk("entry addr", 32'(pc_load_addr), 32'(VECTOR_ADDR));
    endtask : ent

    task automatic ret();
        @(posedge pclk);
        ret_cmd <= 1'b1;
        @(posedge pclk);
        ret_cmd <= 1'b0;
        @(posedge pclk);
        chk("return load", 32'(pc_load & ctx_restore_valid), 32'h0000_0001);
        chk("return addr", 32'(pc_load_addr), 32'(exp_pc));
        chk("restored ctx", 32'(ctx_restore), 32'(exp_ctx));
        chk("gie after return", 32'(global_int_enable), 32'h0000_0001);
    endtask : ret

    task automatic quiet(input int n, input string nm);
        int f;
        f = fl_cnt;
        repeat (n) @(posedge pclk);
        chk(nm, 32'(fl_cnt - f), 32'h0);
    endtask : quiet

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, ret_cmd, two_cmd, async_pin} = '0;
        cen = 1'b1;
        paddr = '0;
        pwdata = '0;
        core_evt = '0;
        pev1 = '0;
        pev2 = '0;
        {failures, num_checks, fl_cnt} = '0;
        rows = '{'{0, OFS_CTRL, 0, 0, 0}, '{0, OFS_PFLAG1, 0, 0, 0},
            '{0, OFS_PFLAG2, 0, 0, 0}, '{0, OFS_PEN2, 0, 0, 0}, '{0, OFS_ISTAT, 0, 0, 0},
            '{0, OFS_IEN, 0, 0, 0}, '{0, OFS_STATE, 0, 1, 0}, '{1, OFS_CTRL, 'h38, 'h38, 0},
            '{1, OFS_PEN1, 'ha5, 'ha5, 0}, '{1, OFS_IEN, 'hf, 'hf, 0},
            '{1, OFS_ISTAT, 'hf, 0, 0}, '{1, OFS_ICLR, 'hf, 0, 0}, '{1, 'h40, 'h1, 0, 1},
            '{1, OFS_PEN1, 0, 0, 0}, '{1, OFS_IEN, 0, 0, 0}, '{1, OFS_CTRL, 0, 0, 0}};
        repeat (3) @(posedge pclk);
        chk("gie in reset", 32'(global_int_enable), 32'h0);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) begin
                apb(1'b1, rows[i].a, rows[i].d);
            end
            apb(1'b0, rows[i].a, 32'h0);
            chk("reg read", rdata, rows[i].e);
            chk("reg error", 32'(rerr), 32'(rows[i].er));
        end
        // events with every enable clear only flag
        @(posedge pclk);
        core_evt <= 2'b11;
        pev1 <= 8'h08;
        pev2 <= 8'h81;
        @(posedge pclk);
        core_evt <= 2'b00;
        pev1 <= 8'h00;
        pev2 <= 8'h00;
        quiet(6, "entry with gie clear");
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("core flags", rdata, 32'h0000_0003);
        apb(1'b0, OFS_PFLAG1, 32'h0);
        chk("flags one", rdata, 32'h0000_0008);
        apb(1'b0, OFS_PFLAG2, 32'h0);
        chk("flags two", rdata, 32'h0000_0081);
        // peripheral pending but group enable clear
        apb(1'b1, OFS_PEN2, 32'h0000_0001);
        apb(1'b1, OFS_CTRL, 32'h0000_0080);
        quiet(8, "entry without group");
        apb(1'b1, OFS_CTRL, 32'h0000_00c0);
        ent(0);
        apb(1'b0, OFS_SHADOW, 32'h0);
        chk("shadow", rdata, 32'(exp_ctx));
        apb(1'b0, OFS_ISTAT, 32'h0);
        chk("status entry", rdata, 32'h0000_0001);
        chk("irq masked", 32'(irq), 32'h0);
        apb(1'b1, OFS_IEN, 32'h0000_0001);
        apb(1'b0, OFS_ISTAT, 32'h0);
        chk("irq raised", 32'(irq), 32'h0000_0001);
        apb(1'b1, OFS_ICLR, 32'h0000_0001);
        apb(1'b0, OFS_ISTAT, 32'h0);
        chk("status cleared", rdata, 32'h0);
        chk("irq cleared", 32'(irq), 32'h0);
        // flag left set re-enters, cleared flag does not
        ret();
        ent(0);
        apb(1'b1, OFS_PFLAG2, 32'h0);
        ret();
        quiet(8, "entry after clear");
        for (int tw = 0; tw < 2; tw++) begin
            apb(1'b1, OFS_CTRL, 32'h0000_0088);
            @(posedge pclk);
            core_evt <= 2'b01;
            @(posedge pclk);
            core_evt <= 2'b00;
            two_cmd <= tw[0];
            @(posedge pclk);
            two_cmd <= 1'b0;
            ent(2);
            chk("sync latency", lat, 3 + tw);
            apb(1'b1, OFS_CTRL, 32'h0000_0008);
            ret();
        end
        apb(1'b1, OFS_CTRL, 32'h0000_00a0);
        @(posedge pclk);
        async_pin <= 1'b1;
        ent(0);
        // four capture cycles of the pin filter come before the three to five
        chk("async latency", 32'(lat >= 7 && lat <= 9), 32'h0000_0001);
        async_pin <= 1'b0;
        apb(1'b1, OFS_CTRL, 32'h0000_0020);
        ret();
        // reset in mid-run leaves everything disabled
        apb(1'b1, OFS_CTRL, 32'h0000_00b8);
        // clock enable low: an enabled event must leave no trace
        cen <= 1'b0;
        core_evt <= 2'b01;
        @(posedge pclk);
        core_evt <= 2'b00;
        repeat (2) @(posedge pclk);
        cen <= 1'b1;
        quiet(6, "entry while frozen");
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl while frozen", rdata, 32'h0000_00b8);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("gie after reset", 32'(global_int_enable), 32'h0);
        presetn <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl after reset", rdata, 32'h0);
        core_evt <= 2'b01;
        @(posedge pclk);
        core_evt <= 2'b00;
        quiet(6, "entry after reset");
        end_of_test();
    end
endmodule : cie_ctrl_tb_top
